// ---- core/alft_consts.svh ----
`ifndef ALFT_CONSTS_SVH
`define ALFT_CONSTS_SVH
`define ALFT_CLK_NS      4
`define ALFT_CTRL_OFS    12'h000
`define ALFT_STAT_OFS    12'h004
`define ALFT_FWD_OFS     12'h008
`define ALFT_DROP_OFS    12'h00C
`define ALFT_CTRL_AGE_EN 0
`define ALFT_CTRL_HALF   1
`define ALFT_CTRL_RST    2'h3
`define ALFT_W0_FLG      15
`define ALFT_W0_PNO      14
`define ALFT_INUSE_SET   2'h3
`define ALFT_INUSE_CLR   2'h0
`define ALFT_AGE_LOAD    8'hBF
`define ALFT_AGE_MAX     8'hC0
`define ALFT_AGE_DEAD    8'h00
`define ALFT_TBL_TOP     15'h7FFF
`define ALFT_IDX_TOP     12'hFFF
`define ALFT_COL_LIMIT   16
`define ALFT_BACKOFF_CAP 10
`define ALFT_SLOT_NS     5120
`define ALFT_SLOT_CYC    ((`ALFT_SLOT_NS + `ALFT_CLK_NS - 1) / `ALFT_CLK_NS)
`define ALFT_BYTE_NS     80
`define ALFT_BYTE_CYC    ((`ALFT_BYTE_NS + `ALFT_CLK_NS - 1) / `ALFT_CLK_NS)
`endif

// ---- core/alft_pkg.sv ----
package alft_pkg;
    typedef enum logic [3:0] {
        S_IDLE = 4'b0000, S_RD0  = 4'b0001, S_RD1  = 4'b0010, S_RD2  = 4'b0011,
        S_CHK  = 4'b0100, S_WR0  = 4'b0101, S_WR1  = 4'b0110, S_WR2  = 4'b0111,
        S_VERD = 4'b1000, S_AG2  = 4'b1001, S_AGC  = 4'b1010, S_AGW2 = 4'b1011,
        S_AG0  = 4'b1100, S_AGW0 = 4'b1101, S_AGN  = 4'b1110
    } alft_st_t;
    typedef enum logic [1:0] {
        R_IDLE = 2'b00, R_TX = 2'b01, R_BACK = 2'b10, R_WAIT = 2'b11
    } alft_tx_st_t;
    typedef struct packed {
        logic [47:0] da;
        logic [47:0] sa;
        logic        port;
        logic        short_frm;
        logic        err;
        logic [10:0] len;
    } alft_frm_t;
    typedef struct packed {
        logic fwd;
        logic filter;
        logic drop;
        logic jam;
    } alft_verdict_t;
    typedef struct packed {
        logic        we;
        logic [14:0] addr;
        logic [15:0] wdata;
    } alft_mem_t;
endpackage

// ---- core/alft_jam.sv ----
`timescale 1ns/100ps
`include "alft_consts.svh"
module alft_jam
    import alft_pkg::*;
#(
    parameter int BYTE_CYC = `ALFT_BYTE_CYC
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic [10:0] len,
    output logic             jam_on
);
    logic [10:0] bytes_r;
    logic [7:0]  div_r;
    // ----------------------------------------
    // jam timer, one byte time per divider tick
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bytes_r <= 11'h000;
            div_r   <= 8'h00;
            jam_on  <= 1'b0;
        end
        else if (start && !jam_on)
        begin
            bytes_r <= len;
            div_r   <= 8'(BYTE_CYC - 1);
            jam_on  <= (len != 11'h000);
        end
        else if (jam_on)
        begin
            if (div_r != 8'h00)
                div_r <= div_r - 8'h01;
            else
            begin
                div_r   <= 8'(BYTE_CYC - 1);
                bytes_r <= bytes_r - 11'h001;
                jam_on  <= (bytes_r != 11'h001);
            end
        end
    end
endmodule // alft_jam

// ---- core/alft_retry.sv ----
`timescale 1ns/100ps
`include "alft_consts.svh"
module alft_retry
    import alft_pkg::*;
#(
    parameter int SLOT_CYC = `ALFT_SLOT_CYC
)(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic q_valid,
    input  wire logic seg_idle,
    input  wire logic col,
    input  wire logic done,
    output logic      tx_start,
    output logic      release_buf,
    output logic      discard
);
    alft_tx_st_t st_r;
    logic [4:0]  ncol_r;
    logic [9:0]  slots_r;
    logic [10:0] cyc_r;
    logic [9:0]  lfsr_r;
    logic [4:0]  k;
    logic [9:0]  mask;
    always_comb
    begin
        k    = (ncol_r + 5'h01 > 5'(`ALFT_BACKOFF_CAP)) ? 5'(`ALFT_BACKOFF_CAP) : ncol_r + 5'h01;
        mask = 10'((11'h001 << k) - 11'h001);
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lfsr_r <= 10'h001;
        else
            lfsr_r <= {lfsr_r[8:0], lfsr_r[9] ^ lfsr_r[6]};
    end
    // ----------------------------------------
    // transmit, collision and backoff sequencing
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r        <= R_IDLE;
            ncol_r      <= 5'h00;
            slots_r     <= 10'h000;
            cyc_r       <= 11'h000;
            tx_start    <= 1'b0;
            release_buf <= 1'b0;
            discard     <= 1'b0;
        end
        else
        begin
            tx_start    <= 1'b0;
            release_buf <= 1'b0;
            discard     <= 1'b0;
            unique case (st_r)
                R_IDLE:
                    if (q_valid && seg_idle)
                    begin
                        tx_start <= 1'b1;
                        ncol_r   <= 5'h00;
                        st_r     <= R_TX;
                    end
                R_TX:
                    if (done)
                    begin
                        release_buf <= 1'b1;
                        st_r        <= R_IDLE;
                    end
                    else if (col && ncol_r == 5'(`ALFT_COL_LIMIT - 1))
                    begin
                        discard     <= 1'b1;
                        release_buf <= 1'b1;
                        st_r        <= R_IDLE;
                    end
                    else if (col)
                    begin
                        ncol_r  <= ncol_r + 5'h01;
                        slots_r <= lfsr_r & mask;
                        cyc_r   <= 11'(SLOT_CYC - 1);
                        st_r    <= R_BACK;
                    end
                R_BACK:
                    if (cyc_r != 11'h000)
                        cyc_r <= cyc_r - 11'h001;
                    else if (slots_r == 10'h000)
                        st_r <= R_WAIT;
                    else
                    begin
                        slots_r <= slots_r - 10'h001;
                        cyc_r   <= 11'(SLOT_CYC - 1);
                    end
                R_WAIT:
                    // the frame stays buffered for as long as the medium stays busy
                    if (seg_idle)
                    begin
                        tx_start <= 1'b1;
                        st_r     <= R_TX;
                    end
            endcase
        end
    end
endmodule // alft_retry

// ---- core/alft_table.sv ----
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "alft_consts.svh"
// Function
// - each entry is four 16-bit words; table spans bytes 0000h to 7FFFh.
// - every received frame has its source address learned into the table; code skips it when no matching or free entry is found.
// - destination on the source port: frame released, not forwarded.
// - short or errored frames to the other port are discarded; good ones stored.
// - source address learning reloads aging index to BFh and sets in-use bits.
// - timed-out entry gets in-use bits cleared and stops aging.
// - half duplex with full buffer jams the source port.
// - jam lasts as long as the triggering frame.
// - collision backs off randomly; sixteenth collision drops frame, frees buffer.
// - frame waiting for the medium stays in buffer indefinitely.
// - broadcast and multicast always forwarded; source still learned; code forwards them only while buf_full is low.
// - stored frames leave in buffer manager link-list order when segment idle.
// - select flag set: id holds MAC bits 11:0, else bits 23:12.
// - occupied home entry pushes learning to next free entry.
// - port bit is 1 for port 1, 0 for port 0.
// - same address on both ports updates one entry, latest frame wins.
// - two in-use bits; set means occupied, clear means free.
// - word 1 holds MAC 39:24, word 2 low byte holds MAC 47:40.
// - word 0 has flag, port, in-use, id; word 2 aging and vendor; word 3 reserved.
// - aging index 01h..C0h alive, 00h aged, others static.
// - each aging trigger decrements every alive entry's aging index once.
module alft_table
    import alft_pkg::*;
#(
    parameter int SLOT_CYC = `ALFT_SLOT_CYC,
    parameter int BYTE_CYC = `ALFT_BYTE_CYC
)(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire alft_frm_t     frm,
    input  wire logic          frm_valid,
    output logic               frm_ready,
    input  wire logic          buf_full,
    output alft_verdict_t      verdict,
    output logic               verdict_valid,
    input  wire logic          age_tick,
    output logic               mem_req,
    output alft_mem_t          mem_cmd,
    input  wire logic          mem_gnt,
    input  wire logic [15:0]   mem_rdata,
    input  wire logic [1:0]    q_valid,
    input  wire logic [1:0]    seg_idle,
    input  wire logic [1:0]    tx_col,
    input  wire logic [1:0]    tx_done,
    output logic [1:0]         tx_start,
    output logic [1:0]         tx_release,
    output logic [1:0]         tx_discard,
    output logic [1:0]         jam_on
);
    alft_st_t      st_r, st_nxt;
    logic [11:0]   idx_r, idx_nxt;
    logic [12:0]   probe_r, probe_nxt;
    logic          phase_r, phase_nxt;
    logic          dknown_r, dknown_nxt;
    logic          dport_r, dport_nxt;
    logic          room_r, room_nxt;
    logic [15:0]   w0_r, w0_nxt;
    logic [15:0]   w1_r, w1_nxt;
    logic [15:0]   w2_r, w2_nxt;
    alft_frm_t     frm_r, frm_nxt;
    alft_mem_t     cmd_nxt;
    logic          req_nxt;
    logic [1:0]    ctrl_r;
    logic          age_pend_r;
    logic [31:0]   fwd_cnt_r;
    logic [31:0]   drop_cnt_r;
    logic [1:0]    jam_go;
    logic [47:0]   key;
    logic          used;
    logic          match;
    logic [7:0]    age;
    alft_verdict_t vd;
    logic          mcast;
    logic          same;
    logic          bad;
    logic          apb_wr;
    logic          apb_hit;

    function automatic logic [14:0] waddr(input logic [11:0] i, input logic [1:0] w);
        waddr = {i, w, 1'b0};
    endfunction

    // ----------------------------------------
    // entry decode
    // ----------------------------------------
    always_comb
    begin
        key   = phase_r ? frm_r.sa : frm_r.da;
        used  = (w0_r[13:12] != `ALFT_INUSE_CLR);
        match = used && (w1_r == key[39:24]) && (w2_r[7:0] == key[47:40])
                && (w0_r[11:0] == (w0_r[`ALFT_W0_FLG] ? key[11:0] : key[23:12]));
        age   = w2_r[15:8];
        mcast = frm_r.da[40];
        same  = !mcast && dknown_r && (dport_r == frm_r.port);
        bad   = frm_r.short_frm || frm_r.err;
    end

    // ----------------------------------------
    // lookup, learning and aging sequencer
    // ----------------------------------------
    always_comb
    begin
        st_nxt     = st_r;
        idx_nxt    = idx_r;
        probe_nxt  = probe_r;
        phase_nxt  = phase_r;
        dknown_nxt = dknown_r;
        dport_nxt  = dport_r;
        room_nxt   = room_r;
        w0_nxt     = w0_r;
        w1_nxt     = w1_r;
        w2_nxt     = w2_r;
        frm_nxt    = frm_r;
        unique case (st_r)
            S_IDLE:
                // a pending sweep waits for frames; once started, a sweep runs through all entries before a frame is taken
                if (frm_valid)
                begin
                    frm_nxt    = frm;
                    phase_nxt  = frm.da[40];
                    idx_nxt    = frm.da[40] ? frm.sa[11:0] : frm.da[11:0];
                    probe_nxt  = 13'h0000;
                    dknown_nxt = 1'b0;
                    room_nxt   = 1'b0;
                    st_nxt     = S_RD0;
                end
                else if (age_pend_r && ctrl_r[`ALFT_CTRL_AGE_EN])
                begin
                    idx_nxt = `ALFT_IDX_TOP;
                    st_nxt  = S_AG2;
                end
            S_RD0:
                if (mem_gnt)
                begin
                    w0_nxt = mem_rdata;
                    st_nxt = S_RD1;
                end
            S_RD1:
                if (mem_gnt)
                begin
                    w1_nxt = mem_rdata;
                    st_nxt = S_RD2;
                end
            S_RD2:
                if (mem_gnt)
                begin
                    w2_nxt = mem_rdata;
                    st_nxt = S_CHK;
                end
            S_CHK:
                if (!phase_r && (match || !used || probe_r == 13'h0FFF))
                begin
                    dknown_nxt = match;
                    dport_nxt  = w0_r[`ALFT_W0_PNO];
                    phase_nxt  = 1'b1;
                    idx_nxt    = frm_r.sa[11:0];
                    probe_nxt  = 13'h0000;
                    st_nxt     = S_RD0;
                end
                else if (phase_r && (match || !used))
                begin
                    room_nxt = 1'b1;
                    st_nxt   = S_WR0;
                end
                else if (phase_r && probe_r == 13'h0FFF)
                    st_nxt = S_VERD;
                else
                begin
                    idx_nxt   = idx_r + 12'h001;
                    probe_nxt = probe_r + 13'h0001;
                    st_nxt    = S_RD0;
                end
            S_WR0:
                if (mem_gnt)
                    st_nxt = S_WR1;
            S_WR1:
                if (mem_gnt)
                    st_nxt = S_WR2;
            S_WR2:
                if (mem_gnt)
                    st_nxt = S_VERD;
            S_VERD:
                st_nxt = S_IDLE;
            S_AG2:
                if (mem_gnt)
                begin
                    w2_nxt = mem_rdata;
                    st_nxt = S_AGC;
                end
            S_AGC:
                // aged and static entries are left untouched
                st_nxt = (age != `ALFT_AGE_DEAD && age <= `ALFT_AGE_MAX) ? S_AGW2 : S_AGN;
            S_AGW2:
                if (mem_gnt)
                    st_nxt = (age == 8'h01) ? S_AG0 : S_AGN;
            S_AG0:
                if (mem_gnt)
                begin
                    w0_nxt = mem_rdata;
                    st_nxt = S_AGW0;
                end
            S_AGW0:
                if (mem_gnt)
                    st_nxt = S_AGN;
            S_AGN:
                if (idx_r == 12'h000)
                    st_nxt = S_IDLE;
                else
                begin
                    idx_nxt = idx_r - 12'h001;
                    st_nxt  = S_AG2;
                end
            default:
                st_nxt = S_IDLE;
        endcase
    end

    // ----------------------------------------
    // memory command for the next state
    // ----------------------------------------
    always_comb
    begin
        req_nxt       = 1'b1;
        cmd_nxt.we    = 1'b0;
        cmd_nxt.addr  = waddr(idx_nxt, 2'd0);
        cmd_nxt.wdata = 16'h0000;
        unique case (st_nxt)
            S_RD0, S_AG0:
                cmd_nxt.addr = waddr(idx_nxt, 2'd0);
            S_RD1:
                cmd_nxt.addr = waddr(idx_nxt, 2'd1);
            S_RD2, S_AG2:
                cmd_nxt.addr = waddr(idx_nxt, 2'd2);
            S_WR0:
            begin
                cmd_nxt.we    = 1'b1;
                cmd_nxt.wdata = {idx_nxt == frm_r.sa[11:0], frm_r.port, `ALFT_INUSE_SET,
                                 (idx_nxt == frm_r.sa[11:0]) ? frm_r.sa[11:0] : frm_r.sa[23:12]};
            end
            S_WR1:
            begin
                cmd_nxt.we    = 1'b1;
                cmd_nxt.addr  = waddr(idx_nxt, 2'd1);
                cmd_nxt.wdata = frm_r.sa[39:24];
            end
            S_WR2:
            begin
                cmd_nxt.we    = 1'b1;
                cmd_nxt.addr  = waddr(idx_nxt, 2'd2);
                cmd_nxt.wdata = {`ALFT_AGE_LOAD, frm_r.sa[47:40]};
            end
            S_AGW2:
            begin
                cmd_nxt.we    = 1'b1;
                cmd_nxt.addr  = waddr(idx_nxt, 2'd2);
                cmd_nxt.wdata = {w2_nxt[15:8] - 8'h01, w2_nxt[7:0]};
            end
            S_AGW0:
            begin
                cmd_nxt.we    = 1'b1;
                cmd_nxt.wdata = {w0_nxt[15:14], `ALFT_INUSE_CLR, w0_nxt[11:0]};
            end
            default:
                req_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r     <= S_IDLE;
            idx_r    <= 12'h000;
            probe_r  <= 13'h0000;
            phase_r  <= 1'b0;
            dknown_r <= 1'b0;
            dport_r  <= 1'b0;
            room_r   <= 1'b0;
            w0_r     <= 16'h0000;
            w1_r     <= 16'h0000;
            w2_r     <= 16'h0000;
            frm_r    <= '0;
            mem_req  <= 1'b0;
            mem_cmd  <= '0;
        end
        else
        begin
            st_r     <= st_nxt;
            idx_r    <= idx_nxt;
            probe_r  <= probe_nxt;
            phase_r  <= phase_nxt;
            dknown_r <= dknown_nxt;
            dport_r  <= dport_nxt;
            room_r   <= room_nxt;
            w0_r     <= w0_nxt;
            w1_r     <= w1_nxt;
            w2_r     <= w2_nxt;
            frm_r    <= frm_nxt;
            mem_req  <= req_nxt;
            mem_cmd  <= cmd_nxt;
        end
    end

    assign frm_ready = (st_r == S_IDLE);

    // ----------------------------------------
    // aging trigger latch, the set wins over the clear
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            age_pend_r <= 1'b0;
        else if (age_tick && ctrl_r[`ALFT_CTRL_AGE_EN])
            age_pend_r <= 1'b1;
        else if (st_nxt == S_AG2 && st_r == S_IDLE)
            age_pend_r <= 1'b0;
    end

    // ----------------------------------------
    // forwarding verdict
    // ----------------------------------------
    always_comb
    begin
        vd.filter = same;
        vd.jam    = !same && buf_full && ctrl_r[`ALFT_CTRL_HALF];
        vd.fwd    = !same && !buf_full && (mcast || !bad);
        vd.drop   = !same && !vd.fwd && !vd.jam;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            verdict       <= '0;
            verdict_valid <= 1'b0;
            jam_go        <= 2'b00;
        end
        else
        begin
            verdict_valid <= (st_r == S_VERD);
            jam_go        <= 2'b00;
            if (st_r == S_VERD)
            begin
                verdict            <= vd;
                jam_go[frm_r.port] <= vd.jam;
            end
        end
    end

    // ----------------------------------------
    // per-port transmit and jam
    // ----------------------------------------
    for (genvar p = 0; p < 2; p++)
    begin : g_port
        alft_retry #(
            .SLOT_CYC    (SLOT_CYC)
        ) u_retry (
            .pclk        (pclk),
            .presetn     (presetn),
            .q_valid     (q_valid[p]),
            .seg_idle    (seg_idle[p]),
            .col         (tx_col[p]),
            .done        (tx_done[p]),
            .tx_start    (tx_start[p]),
            .release_buf (tx_release[p]),
            .discard     (tx_discard[p])
        );
        alft_jam #(
            .BYTE_CYC    (BYTE_CYC)
        ) u_jam (
            .pclk        (pclk),
            .presetn     (presetn),
            .start       (jam_go[p]),
            .len         (frm_r.len),
            .jam_on      (jam_on[p])
        );
    end

    // ----------------------------------------
    // apb registers, zero wait states
    // ----------------------------------------
    assign apb_wr  = psel && penable && pwrite;
    assign apb_hit = (paddr == `ALFT_CTRL_OFS) || (paddr == `ALFT_STAT_OFS)
                     || (paddr == `ALFT_FWD_OFS) || (paddr == `ALFT_DROP_OFS);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !apb_hit;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_r <= `ALFT_CTRL_RST;
        else if (apb_wr && paddr == `ALFT_CTRL_OFS)
            ctrl_r <= pwdata[1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fwd_cnt_r  <= 32'h0000_0000;
            drop_cnt_r <= 32'h0000_0000;
        end
        else if (verdict_valid)
        begin
            fwd_cnt_r  <= fwd_cnt_r + {31'h0000_0000, verdict.fwd};
            drop_cnt_r <= drop_cnt_r + {31'h0000_0000, !verdict.fwd};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                `ALFT_CTRL_OFS: prdata <= {30'h0000_0000, ctrl_r};
                `ALFT_STAT_OFS: prdata <= {19'h0_0000, room_r, dknown_r, jam_on, age_pend_r, st_r, idx_r[3:0]};
                `ALFT_FWD_OFS:  prdata <= fwd_cnt_r;
                `ALFT_DROP_OFS: prdata <= drop_cnt_r;
                default:        prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // alft_table

// ---- tb/alft_table_props.sv ----
`timescale 1ns/100ps
module alft_table_props import alft_pkg::*; (
    input wire logic pclk, presetn, mem_req, mem_gnt, verdict_valid,
    input wire alft_mem_t mem_cmd,
    input wire alft_verdict_t verdict,
    input wire logic [1:0] jam_on, tx_start, tx_release, tx_discard, seg_idle);
// ----------
// checks
// ----------
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
chk_word_align:
    assert property (mem_req |-> !mem_cmd.addr[0]) else $error("odd address");
chk_no_reserved:
    assert property (mem_req |-> mem_cmd.addr[2:1] != 2'h3) else $error("reserved word");
chk_age_load:
    assert property (mem_req && mem_cmd.we && mem_cmd.addr[2:1] == 2'h2 |-> mem_cmd.wdata[15:8] <= 8'hBF)
        else $error("age above load");
chk_mem_hold:
    assert property (mem_req && !mem_gnt |=> mem_req && $stable(mem_cmd)) else $error("request moved");
chk_same_port:
    assert property (verdict_valid |-> !(verdict.fwd && verdict.filter)) else $error("filter and forward");
chk_jam_start:
    assert property (verdict_valid && verdict.jam |-> ##[1:2] |jam_on) else $error("no jam");
chk_discard_free:
    assert property (tx_discard != 2'h0 |-> tx_release == tx_discard) else $error("buffer kept");
chk_start_idle:
    assert property (tx_start[0] |-> $past(seg_idle[0])) else $error("start on busy segment");
cov_fwd: cover property (verdict_valid && verdict.fwd);
cov_filter: cover property (verdict_valid && verdict.filter);
cov_jam: cover property (|jam_on);
cov_discard: cover property (|tx_discard);
endmodule // alft_table_props
bind alft_table alft_table_props alft_table_props_inst (.*);

// ---- tb/alft_sram.sv ----
`timescale 1ns/100ps
module alft_sram import alft_pkg::*; #(parameter int LAT = 2) (
    input wire logic pclk, presetn, mem_req,
    input wire alft_mem_t mem_cmd,
    output logic mem_gnt,
    output logic [15:0] mem_rdata);
logic [15:0] m [0:16383];
int w;
initial foreach (m[i]) m[i] = 16'h0000;
// idle data bus toggles so a stale read never looks valid
always @(posedge pclk or negedge presetn)
    if (!presetn) begin mem_gnt <= 0; w <= 0; mem_rdata <= 16'h0000; end
    else if (mem_req && !mem_gnt && w >= LAT)
    begin
        mem_gnt <= 1; w <= 0; mem_rdata <= m[mem_cmd.addr[14:1]];
        if (mem_cmd.we) m[mem_cmd.addr[14:1]] <= mem_cmd.wdata;
    end
    else begin mem_gnt <= 0; w <= (mem_req && !mem_gnt) ? w + 1 : 0; mem_rdata <= ~mem_rdata; end
endmodule // alft_sram

// ---- tb/alft_table_tb.sv ----
`timescale 1ns/100ps
module alft_table_tb import alft_pkg::*;;
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, frm_valid = 0, buf_full = 0, age_tick = 0;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, prdata, rd;
logic pready, pslverr, er, frm_ready, verdict_valid, mem_req, mem_gnt;
alft_frm_t frm = '0;
alft_verdict_t verdict;
alft_mem_t mem_cmd;
logic [15:0] mem_rdata;
logic [1:0] q_valid = 0, seg_idle = 0, tx_col = 0, tx_done = 0, tx_start, tx_release, tx_discard, jam_on;
int error_cnt = 0, checked = 0, n;
localparam logic [47:0] A = 48'h0246_8ACE_1357, D = 48'h0A12_3456_7357, M = 48'h0135_7924_6801;
always #2 pclk = ~pclk;
alft_table #(.SLOT_CYC(4), .BYTE_CYC(2)) alft_table_inst (.*);
alft_sram alft_sram_inst (.*);
task automatic chk(input logic [31:0] s, e);
    checked++;
    if (s !== e) begin error_cnt++; $display("Error t=%0t seen=%h exp=%h", $time, s, e); end
endtask
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d = 32'h0000_0000);
    @(posedge pclk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    do @(posedge pclk); while (!pready);
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
endtask
task automatic send(input logic [47:0] da, sa, input logic p, s, input logic [10:0] l);
    @(posedge pclk); frm <= {da, sa, p, s, 1'b0, l}; frm_valid <= 1;
    do @(posedge pclk); while (!frm_ready);
    frm_valid <= 0;
    for (int i = 0; i < 3000 && !verdict_valid; i++) @(posedge pclk);
    if (!verdict_valid) error_cnt++;
endtask
task automatic ent(input logic [11:0] i, input logic [15:0] w0, w1, w2);
    chk(alft_sram_inst.m[{i, 2'd0}], w0); chk(alft_sram_inst.m[{i, 2'd1}], w1);
    chk(alft_sram_inst.m[{i, 2'd2}], w2);
endtask
task automatic col_once;
    for (int i = 0; i < 9000 && !tx_start[0]; i++) @(posedge pclk);
    if (!tx_start[0]) error_cnt++;
    tx_col <= 2'h1; @(posedge pclk); tx_col <= 2'h0;
    repeat (3) begin @(posedge pclk); n += tx_discard[0]; end
endtask
task automatic print_verdict;
    $display("checked=%0d errors=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
initial begin repeat (100000) @(posedge pclk); error_cnt++; print_verdict; end
initial
begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000); chk(rd, 32'h0000_0003);
    apb(0, 12'h010); chk(er, 1'b1); chk(rd, 32'h0000_0000);
    send(M, A, 1, 0, 64); chk(verdict, 4'h8);
    ent(12'h357, 16'hF357, 16'h468A, 16'hBF02);
    send(A, D, 1, 0, 64); chk(verdict, 4'h4);
    ent(12'h358, 16'h7567, 16'h1234, 16'hBF0A);
    send(M, A, 0, 0, 64); chk(alft_sram_inst.m[{12'h357, 2'd0}], 16'hB357);
    send(A, D, 1, 1, 64); chk(verdict, 4'h2);
    buf_full <= 1; send(A, D, 1, 0, 5); chk(verdict.jam, 1);
    buf_full <= 0; n = 0;
    for (int i = 0; i < 40; i++) begin @(posedge pclk); n += jam_on[1]; end
    chk(n, 10);
    apb(1, 12'h000, 32'h0000_0001); apb(0, 12'h000); chk(rd, 32'h0000_0001);
    buf_full <= 1; send(A, D, 1, 0, 5); chk(verdict, 4'h2);
    buf_full <= 0;
    alft_sram_inst.m[{12'h100, 2'd0}] = 16'h3100; alft_sram_inst.m[{12'h100, 2'd2}] = 16'h0155;
    alft_sram_inst.m[{12'h101, 2'd2}] = 16'hC155;
    age_tick <= 1; @(posedge pclk); age_tick <= 0; repeat (20) @(posedge pclk);
    for (int i = 0; i < 40000 && !frm_ready; i++) @(posedge pclk);
    if (!frm_ready) error_cnt++;
    chk(alft_sram_inst.m[{12'h357, 2'd2}], 16'hBE02);
    chk(alft_sram_inst.m[{12'h100, 2'd0}], 16'h0100);
    chk(alft_sram_inst.m[{12'h100, 2'd2}], 16'h0055);
    chk(alft_sram_inst.m[{12'h101, 2'd2}], 16'hC155);
    q_valid <= 2'h1; seg_idle <= 2'h1; n = 0;
    repeat (15) col_once;
    chk(n, 0);
    col_once; chk(n, 1);
    tx_done <= 2'h1; @(posedge pclk); tx_done <= 2'h0; @(posedge pclk);
    chk(tx_release, 2'h1);
    q_valid <= 2'h0;
    print_verdict;
end
endmodule // alft_table_tb
